// File: src/pssp_pkg.sv
// shared constants and types for the synchronous sram port pair
// assumes one 50 MHz clock shared by both ends
package pssp_pkg;
   // organisation: four 9-bit lanes, 128K words
   localparam int LANES    = 4;
   localparam int LANE_W   = 9;
   localparam int DATA_W   = LANES * LANE_W;
   localparam int ADDR_W   = (LANES == 4) ? 17 : 18;
   localparam int MEM_DEPTH = 1 << ADDR_W;
   localparam int BURST_W  = 2;
   localparam int SYNC_N   = 3;
   // pipeline depth of read and write data, in cycles
   localparam int LAT_PIPE = 2;
   localparam int LAT_FLOW = 1;

   // controller register map, byte addresses
   localparam int AXI_AW      = 8;
   localparam logic [7:0] OFS_ADDR   = 8'h00;
   localparam logic [7:0] OFS_WD_LO  = 8'h04;
   localparam logic [7:0] OFS_WD_HI  = 8'h08;
   localparam logic [7:0] OFS_RD_LO  = 8'h0c;
   localparam logic [7:0] OFS_RD_HI  = 8'h10;
   localparam logic [7:0] OFS_CTRL   = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_CFG    = 8'h1c;
   localparam int HI_W = DATA_W - 32;
   // control fields
   localparam int CTRL_GO  = 0;
   localparam int CTRL_WR  = 1;
   localparam int CTRL_STB = 2;
   // config fields and their reset values
   localparam int CFG_FLOW   = 0;
   localparam int CFG_ILV    = 1;
   localparam int CFG_SLEEP  = 2;
   localparam logic [2:0] CFG_RST = 3'h0;
   // status fields
   localparam int STS_BUSY = 0;
   localparam int STS_DONE = 1;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      CMD_IDLE  = 2'b00,
      CMD_READ  = 2'b01,
      CMD_WRITE = 2'b10
   } pssp_cmd_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_ACT  = 1'b1
   } pssp_state_t;

   // low address bits of a burst step, linear or interleaved
   function automatic logic [BURST_W-1:0] pssp_burst_low(
      input logic [BURST_W-1:0] start,
      input logic [BURST_W-1:0] step,
      input logic               linear);
      pssp_burst_low = linear ? start + step : start ^ step;
   endfunction

   // data latency for the selected read timing
   function automatic logic [1:0] pssp_lat(input logic flow);
      pssp_lat = flow ? 2'(LAT_FLOW) : 2'(LAT_PIPE);
   endfunction
endpackage

// File: src/pssp_if.sv
// pin bundle between the sram port and its memory controller
// assumes the bench supplies the clock to both ends
`timescale 1ns/1ps
interface pssp_if;
   import pssp_pkg::*;
   logic              clk_en_n;
   logic [ADDR_W-1:0] addr;
   logic              advance_load;
   logic              write_en_n;
   logic [LANES-1:0]  lane_strobe_n;
   logic              chip_sel_first_n;
   logic              chip_sel_second;
   logic              chip_sel_third_n;
   logic              out_en_n;
   logic              sleep_req;
   logic              pipe_mode_sel_n;
   logic              linear_order_sel_n;
   logic [DATA_W-1:0] ctl_dq_out;
   logic              ctl_dq_oe;
   logic [DATA_W-1:0] dev_dq_out;
   logic              dev_dq_oe;
   logic [DATA_W-1:0] dq;

   // resolved data bus level; an undriven bus reads as zero
   assign dq = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : '0);

   modport dev (
      input  clk_en_n, addr, advance_load, write_en_n, lane_strobe_n,
      input  chip_sel_first_n, chip_sel_second, chip_sel_third_n,
      input  out_en_n, sleep_req, pipe_mode_sel_n, linear_order_sel_n,
      input  dq,
      output dev_dq_out, dev_dq_oe
   );
   modport ctl (
      output clk_en_n, addr, advance_load, write_en_n, lane_strobe_n,
      output chip_sel_first_n, chip_sel_second, chip_sel_third_n,
      output out_en_n, sleep_req, pipe_mode_sel_n, linear_order_sel_n,
      output ctl_dq_out, ctl_dq_oe,
      input  dq
   );
endinterface

// File: src/pssp_device.sv
// sram end: array, burst counter, read and late-write pipelines
// assumes the controller drives every synchronous pin on sys_clk
// What this block does
// - synchronous pins sampled on rising clock edge
// - clock enable high freezes all but the synchronisers
// - controller loads address with advance low
// - selected only when all three selects active
// - read starts on load, select, write high
// - pipelined read data leaves one edge later
// - write starts on select, enable, write low
// - each strobe gates one 9-bit lane
// - all strobes high makes write a no-op
// - pipelined write data taken third edge
// - output enable turns drivers off instantly
// - sleep asynchronous, ignores commands, powers down
// - mode strap picks flow-through or pipelined
// - burst order pin held static
// - two low address bits preload counter
// - write pulse timed internally from clock
// - write may directly follow a read
// - advance high steps the burst counter
// - counter wraps after four addresses
// - flow-through write data on second edge
// - drivers off during write cycles
`timescale 1ns/1ps
module pssp_device
   import pssp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   pssp_if.dev      bus
);
   // storage; no reset, contents undefined at power-up
   logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];

   // burst state held between edges
   pssp_cmd_t             cur_cmd;
   logic [ADDR_W-1:0]     base_addr;
   logic [BURST_W-1:0]    start_low;
   logic [BURST_W-1:0]    step;

   // first and second pipeline stages
   pssp_cmd_t             s1_cmd;
   logic [ADDR_W-1:0]     s1_addr;
   logic [LANES-1:0]      s1_strb_n;
   pssp_cmd_t             s2_cmd;
   logic [ADDR_W-1:0]     s2_addr;
   logic [LANES-1:0]      s2_strb_n;

   // pipelined output register
   logic [DATA_W-1:0]     q_reg;

   // static and slow pins, three-stage synchronisers
   logic [SYNC_N-1:0]     sh0;
   logic [SYNC_N-1:0]     sh1;
   logic [SYNC_N-1:0]     sh2;
   logic                  sleep_q;
   logic                  pipe_q;
   logic                  linear_q;
   // idle pin levels: awake, pipelined, linear; matching them at reset
   // keeps a false mode change out of the first edges after release
   localparam logic [SYNC_N-1:0] PINS_IDLE = {1'b0, 1'b1, 1'b0};

   // decoded controls
   wire selected;
   wire edge_taken;
   wire load;
   wire linear_on;
   wire [BURST_W-1:0] next_step;
   wire [BURST_W-1:0] next_low;
   pssp_cmd_t         next_cmd;
   wire [ADDR_W-1:0]  next_addr;
   pssp_cmd_t         wr_cmd;
   wire [ADDR_W-1:0]  wr_addr;
   wire [LANES-1:0]   wr_strb_n;
   wire               do_write;
   wire               rd_stage;
   wire [SYNC_N-1:0]  pins_in;

   // all three selects must agree before anything starts
   assign selected = !bus.chip_sel_first_n
                   & bus.chip_sel_second
                   & !bus.chip_sel_third_n;

   // a stalled or sleeping edge changes nothing but the synchronisers
   assign edge_taken = !bus.clk_en_n & !sleep_q;
   assign load       = !bus.advance_load;
   assign linear_on  = linear_q;

   // burst step wraps by width: four addresses then back to start
   assign next_step = step + 2'(1);
   assign next_low  = pssp_burst_low(start_low, next_step,
                                     linear_on);

   // load picks a new command; a continue keeps the last type,
   // so a deselect followed by continue stays deselected
   always_comb begin
      if (load && selected && bus.write_en_n) begin
         next_cmd = CMD_READ;
      end else if (load && selected) begin
         next_cmd = CMD_WRITE;
      end else if (load) begin
         next_cmd = CMD_IDLE;
      end else begin
         next_cmd = cur_cmd;
      end
   end

   // fresh pin address on load, counter address on advance
   assign next_addr = load ? bus.addr
                    : {base_addr[ADDR_W-1:BURST_W], next_low};

   // burst counter, preloaded from the two low address pins
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cur_cmd   <= CMD_IDLE;
         base_addr <= '0;
         start_low <= '0;
         step      <= '0;
      end else if (edge_taken) begin
         cur_cmd <= next_cmd;
         if (load) begin
            base_addr <= bus.addr;
            start_low <= bus.addr[BURST_W-1:0];
            step      <= '0;
         end else begin
            step <= next_step;
         end
      end
   end

   // command pipeline: selects, strobes, address on the first edge
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s1_cmd    <= CMD_IDLE;
         s1_addr   <= '0;
         s1_strb_n <= '1;
         s2_cmd    <= CMD_IDLE;
         s2_addr   <= '0;
         s2_strb_n <= '1;
      end else if (edge_taken) begin
         s1_cmd    <= next_cmd;
         s1_addr   <= next_addr;
         s1_strb_n <= bus.lane_strobe_n;
         s2_cmd    <= s1_cmd;
         s2_addr   <= s1_addr;
         s2_strb_n <= s1_strb_n;
      end
   end

   // late write: stage two when pipelined, stage one for flow-through
   assign wr_cmd    = pipe_q ? s2_cmd : s1_cmd;
   assign wr_addr   = pipe_q ? s2_addr : s1_addr;
   assign wr_strb_n = pipe_q ? s2_strb_n : s1_strb_n;
   // all strobes high leaves every lane untouched
   assign do_write  = edge_taken && wr_cmd == CMD_WRITE
                    && !(&wr_strb_n);

   // the clock edge itself is the write pulse, one lane per strobe
   always_ff @(posedge sys_clk) begin
      if (do_write) begin
         for (int l = 0; l < LANES; l++) begin
            if (!wr_strb_n[l]) begin
               mem[wr_addr][l*LANE_W +: LANE_W] <=
                  bus.dq[l*LANE_W +: LANE_W];
            end
         end
      end
   end

   // output register loads at the edge after the read was taken
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         q_reg <= '0;
      end else if (edge_taken && s1_cmd == CMD_READ) begin
         q_reg <= mem[s1_addr];
      end
   end

   // flow-through trades the output register for one cycle less
   assign bus.dev_dq_out = pipe_q ? q_reg : mem[s1_addr];

   // drive only for reads; stall keeps a pipelined read on the bus
   assign rd_stage = pipe_q ? (s2_cmd == CMD_READ)
                            : (s1_cmd == CMD_READ);
   // output enable and sleep gate the drivers without the clock
   assign bus.dev_dq_oe = rd_stage
                        & !bus.out_en_n
                        & !bus.sleep_req;

   // sleep, mode and order pins come from outside the clock domain
   assign pins_in = {bus.sleep_req, bus.pipe_mode_sel_n,
                     bus.linear_order_sel_n};

   // three-stage synchroniser; first stage only feeds the second
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sh0 <= PINS_IDLE;
         sh1 <= PINS_IDLE;
         sh2 <= PINS_IDLE;
      end else begin
         sh0 <= pins_in;
         sh1 <= sh0;
         sh2 <= sh1;
      end
   end

   // a level counts once stages two and three agree
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sleep_q  <= 1'b0;
         pipe_q   <= 1'b1;
         linear_q <= 1'b1;
      end else begin
         if (sh1[2] == sh2[2]) sleep_q <= sh2[2];
         if (sh1[1] == sh2[1]) pipe_q <= sh2[1];
         if (sh1[0] == sh2[0]) linear_q <= !sh2[0];
      end
   end
endmodule

// File: src/pssp_ctrl.sv
// memory controller end: axi4-lite registers, one access at a time
// assumes the sram end shares sys_clk and samples on rising edges
`timescale 1ns/1ps
module pssp_ctrl
   import pssp_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output wire logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output wire logic              s_axi_wready,
   output logic      [1:0]        s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output wire logic              s_axi_arready,
   output logic      [31:0]       s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   pssp_if.ctl                    bus
);
   // byte-enable merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] be);
      for (int b = 0; b < 4; b++) begin
         if (be[b]) old[b*8 +: 8] = data[b*8 +: 8];
      end
      merge = old;
   endfunction

   logic              aw_hold;
   logic [AXI_AW-1:0] aw_addr;
   logic              w_hold;
   logic [31:0]       w_data;
   logic [3:0]        w_be;
   logic [31:0]       addr_reg;
   logic [31:0]       wd_lo;
   logic [31:0]       wd_hi;
   logic [2:0]        cfg;
   logic [31:0]       ctrl_reg;
   logic [DATA_W-1:0] rd_data;
   logic              done;
   pssp_state_t       state;
   logic [1:0]        ph;
   logic              issue;
   logic              op_wr;
   logic [31:0]       rd_mux;
   logic              rd_ok;

   wire wr_fire;
   wire wr_ok;
   wire go;
   wire [31:0] wr_word;
   wire [1:0]  lat;

   // one write at a time: both halves held, then the response
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
   assign wr_ok   = aw_addr <= OFS_CFG && aw_addr[1:0] == 2'h0
                    && aw_addr != OFS_RD_LO && aw_addr != OFS_RD_HI
                    && aw_addr != OFS_STATUS;
   assign wr_word = merge(32'h0, w_data, w_be);
   // a start while busy is dropped; status shows it never began
   assign go = wr_fire && aw_addr == OFS_CTRL && w_be[0]
               && w_data[CTRL_GO] && state == ST_IDLE;
   assign lat = pssp_lat(cfg[CFG_FLOW]);

   // register read decode
   always_comb begin
      rd_ok  = 1'b1;
      rd_mux = 32'h0;
      if (s_axi_araddr == OFS_ADDR) begin
         rd_mux = addr_reg;
      end else if (s_axi_araddr == OFS_WD_LO) begin
         rd_mux = wd_lo;
      end else if (s_axi_araddr == OFS_WD_HI) begin
         rd_mux = wd_hi;
      end else if (s_axi_araddr == OFS_RD_LO) begin
         rd_mux = rd_data[31:0];
      end else if (s_axi_araddr == OFS_RD_HI) begin
         rd_mux = {{(32-HI_W){1'b0}}, rd_data[DATA_W-1:32]};
      end else if (s_axi_araddr == OFS_CTRL) begin
         rd_mux = ctrl_reg & ~32'h1;
      end else if (s_axi_araddr == OFS_STATUS) begin
         rd_mux = {30'h0, done, state == ST_ACT};
      end else if (s_axi_araddr == OFS_CFG) begin
         rd_mux = {29'h0, cfg};
      end else begin
         rd_ok = 1'b0;
      end
   end

   // axi channel holding and responses
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         aw_hold <= 1'b0;
         aw_addr <= '0;
         w_hold  <= 1'b0;
         w_data  <= 32'h0;
         w_be    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= 32'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_be   <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // software registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         addr_reg <= 32'h0;
         wd_lo    <= 32'h0;
         wd_hi    <= 32'h0;
         ctrl_reg <= 32'h0;
         cfg      <= CFG_RST;
      end else if (wr_fire && wr_ok) begin
         if (aw_addr == OFS_ADDR) addr_reg <= merge(addr_reg, w_data, w_be);
         if (aw_addr == OFS_WD_LO) wd_lo <= merge(wd_lo, w_data, w_be);
         if (aw_addr == OFS_WD_HI) wd_hi <= merge(wd_hi, w_data, w_be);
         if (aw_addr == OFS_CTRL) ctrl_reg <= wr_word;
         if (aw_addr == OFS_CFG) cfg <= wr_word[2:0];
      end
   end

   // access sequencer: command cycle, then wait out the data latency
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state   <= ST_IDLE;
         ph      <= 2'h0;
         issue   <= 1'b0;
         op_wr   <= 1'b0;
         done    <= 1'b0;
         rd_data <= '0;
         bus.addr          <= '0;
         bus.write_en_n    <= 1'b1;
         bus.lane_strobe_n <= '1;
         bus.ctl_dq_out    <= '0;
         bus.ctl_dq_oe     <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (go) begin
                  state <= ST_ACT;
                  ph    <= 2'h0;
                  issue <= 1'b1;
                  op_wr <= w_data[CTRL_WR];
                  done  <= 1'b0;
                  bus.addr       <= addr_reg[ADDR_W-1:0];
                  bus.write_en_n <= !w_data[CTRL_WR];
                  bus.lane_strobe_n <=
                     w_data[CTRL_STB +: LANES];
               end
            end
            ST_ACT: begin
               ph    <= ph + 2'h1;
               issue <= 1'b0;
               bus.write_en_n    <= 1'b1;
               bus.lane_strobe_n <= '1;
               // data set one edge before the edge that takes it
               if (op_wr && ph == lat - 2'h1) begin
                  bus.ctl_dq_out <= {wd_hi[HI_W-1:0], wd_lo};
                  bus.ctl_dq_oe  <= 1'b1;
               end
               if (ph == lat) begin
                  state <= ST_IDLE;
                  done  <= 1'b1;
                  bus.ctl_dq_oe <= 1'b0;
                  if (!op_wr) rd_data <= bus.dq;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // selects follow the command cycle; idle cycles are deselects
   assign bus.chip_sel_first_n   = !issue;
   assign bus.chip_sel_second    = issue;
   assign bus.chip_sel_third_n   = !issue;
   assign bus.advance_load       = 1'b0;
   assign bus.clk_en_n           = 1'b0;
   assign bus.out_en_n           = 1'b0;
   assign bus.sleep_req          = cfg[CFG_SLEEP];
   assign bus.pipe_mode_sel_n    = !cfg[CFG_FLOW];
   assign bus.linear_order_sel_n = cfg[CFG_ILV];
endmodule

// File: verification/pssp_assertions.sv
// checker for the sram link: pin timing between controller and sram
// assumes plain bundle signals, one clock, reset active low
`timescale 1ns/1ps
module pssp_assertions
   import pssp_pkg::*;
(
   input wire logic             sys_clk,
   input wire logic             rstn,
   input wire logic             clk_en_n,
   input wire logic             advance_load,
   input wire logic             write_en_n,
   input wire logic [LANES-1:0] lane_strobe_n,
   input wire logic             chip_sel_first_n,
   input wire logic             chip_sel_second,
   input wire logic             chip_sel_third_n,
   input wire logic             sleep_req,
   input wire logic             pipe_mode_sel_n,
   input wire logic             linear_order_sel_n,
   input wire logic             ctl_dq_oe,
   input wire logic             dev_dq_oe
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   // command decode as the sram sees it; sleep blocks commands
   wire sel = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
   wire go  = sel && !clk_en_n && !advance_load && !sleep_req;
   wire rd  = go && write_en_n;
   wire wr  = go && !write_en_n && !(&lane_strobe_n);
   wire pip = pipe_mode_sel_n;

   chk_pipe_read: assert property (rd && pip |=>
      !dev_dq_oe ##1 dev_dq_oe ##1 !dev_dq_oe)
      else $error("pipelined read data not one edge late");
   chk_flow_read: assert property (rd && !pip |=>
      dev_dq_oe ##1 !dev_dq_oe)
      else $error("flow-through read data misplaced");
   chk_pipe_wdata: assert property (wr && pip |=>
      !ctl_dq_oe ##1 ctl_dq_oe ##1 !ctl_dq_oe)
      else $error("pipelined write data not at third edge");
   chk_flow_wdata: assert property (wr && !pip |=>
      ctl_dq_oe ##1 !ctl_dq_oe)
      else $error("flow-through write data not at second edge");
   chk_write_quiet: assert property (wr |=> !dev_dq_oe [*3])
      else $error("sram drove bus during write");
   chk_no_clash: assert property (!(ctl_dq_oe && dev_dq_oe))
      else $error("both ends drive the data bus");
   chk_sleep_off: assert property (sleep_req |-> !dev_dq_oe)
      else $error("sram drives bus while asleep");
   chk_load_addr: assert property (sel |-> !advance_load)
      else $error("command issued without address load");
   chk_straps_static: assert property (sel |->
      $stable(linear_order_sel_n) && $stable(pipe_mode_sel_n))
      else $error("strap moved at a command");
   chk_rise_cause: assert property ($rose(dev_dq_oe) |->
      (pip ? $past(rd, 2) : $past(rd)))
      else $error("sram drove bus without a selected read");

   // main traffic seen
   cover property (rd && pip);
   cover property (rd && !pip);
   cover property (go && !write_en_n && &lane_strobe_n);
   cover property (sleep_req ##1 sleep_req);
endmodule

// File: verification/pipelined_sync_sram_port_tb.sv
// self-checking bench: controller and sram joined by the link bundle
// assumes a 50 MHz clock; registers reached over axi4-lite only
`timescale 1ns/1ps
module pipelined_sync_sram_port_tb;
   import pssp_pkg::*;
   logic        sys_clk, rstn;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic        awvalid, wvalid, bready, arvalid, rready;
   wire         awready, wready, arready;
   logic [1:0]  bresp, rresp, rsp;
   logic        bvalid, rvalid;
   integer      seed, mismatches, checks_done;
   logic [35:0] mem [int];

   pssp_if bus ();
   pssp_device pssp_device_i (.sys_clk(sys_clk), .rstn(rstn), .bus(bus));
   pssp_ctrl pssp_ctrl_i (
      .sys_clk(sys_clk), .rstn(rstn), .bus(bus),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   pssp_assertions pssp_assertions_i (
      .sys_clk(sys_clk), .rstn(rstn), .clk_en_n(bus.clk_en_n),
      .advance_load(bus.advance_load), .write_en_n(bus.write_en_n),
      .lane_strobe_n(bus.lane_strobe_n), .sleep_req(bus.sleep_req),
      .chip_sel_first_n(bus.chip_sel_first_n),
      .chip_sel_second(bus.chip_sel_second),
      .chip_sel_third_n(bus.chip_sel_third_n),
      .pipe_mode_sel_n(bus.pipe_mode_sel_n),
      .linear_order_sel_n(bus.linear_order_sel_n),
      .ctl_dq_oe(bus.ctl_dq_oe), .dev_dq_oe(bus.dev_dq_oe));

   // free-running 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [35:0] e, g);
      checks_done++;
      if (e !== g) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // expected word: only lanes with a low strobe take new data
   function automatic logic [35:0] merge(logic [35:0] o, n, logic [3:0] s);
      for (int l = 0; l < LANES; l++)
         if (!s[l]) o[l*LANE_W +: LANE_W] = n[l*LANE_W +: LANE_W];
      return o;
   endfunction

   // one axi4-lite access; flags sampled mid-cycle, acted on at the edge
   task automatic axi(input bit w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      bit ha, hw, hr, hd;
      q = 32'h0;
      @(posedge sys_clk);
      awaddr  <= a;
      araddr  <= a;
      wdata   <= d;
      awvalid <= w;
      wvalid  <= w;
      bready  <= w;
      arvalid <= !w;
      rready  <= !w;
      forever begin // only the watchdog ends a hung wait
         @(negedge sys_clk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hr = arvalid & arready;
         hd = (bvalid & bready) | (rvalid & rready);
         q = rdata;
         rsp = w ? bresp : rresp;
         @(posedge sys_clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hr) arvalid <= 1'b0;
         if (hd) begin
            bready <= 1'b0;
            rready <= 1'b0;
            return;
         end
      end
   endtask

   // one sram operation through the controller; read word returned
   task automatic op(input bit w, input logic [16:0] a,
                     input logic [35:0] d, input logic [3:0] s,
                     output logic [35:0] q);
      logic [31:0] lo, hi;
      int n;
      axi(1, OFS_ADDR, 32'(a), lo);
      axi(1, OFS_WD_LO, d[31:0], lo);
      axi(1, OFS_WD_HI, 32'(d[35:32]), lo);
      axi(1, OFS_CTRL, {26'h0, s, w, 1'b1}, lo);
      chk("bresp", 36'(RESP_OKAY), 36'(rsp));
      lo = 32'h1;
      for (n = 0; n < 20 && lo[STS_BUSY]; n++)
         axi(0, OFS_STATUS, 32'h0, lo);
      chk("done", 36'h1, 36'(lo[STS_DONE]));
      axi(0, OFS_RD_LO, 32'h0, lo);
      axi(0, OFS_RD_HI, 32'h0, hi);
      chk("rresp", 36'(RESP_OKAY), 36'(rsp));
      q = {hi[HI_W-1:0], lo};
   endtask

   // main sequence: registers, four strap modes, sleep
   initial begin
      logic [16:0] a;
      logic [35:0] d, q;
      logic [3:0]  s;
      logic [31:0] r;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      seed = 68;
      mismatches = 0;
      checks_done = 0;
      rstn = 1'b0;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      axi(0, OFS_CFG, 32'h0, r);
      chk("cfg", 36'(CFG_RST), 36'(r));
      axi(0, 8'h20, 32'h0, r);
      chk("rd_resp", 36'(RESP_SLVERR), 36'(rsp));
      axi(1, OFS_STATUS, 32'h3, r);
      chk("wr_resp", 36'(RESP_SLVERR), 36'(rsp));
      axi(1, OFS_WD_LO, 32'h5a0f_c3e1, r);
      axi(0, OFS_WD_LO, 32'h0, r);
      chk("wd_lo", 36'h05a0fc3e1, 36'(r));
      $display("test registers done");
      for (int m = 0; m < 4; m++) begin
         axi(1, OFS_CFG, 32'(m), r);
         repeat (6) @(posedge sys_clk); // straps need time to settle
         for (int i = 0; i < 10; i++) begin
            a = (i == 0) ? '1 : 17'($random(seed) & 15);
            d = 36'({$random(seed), $random(seed)});
            s = mem.exists(a) ? 4'($random(seed)) : 4'h0;
            op(1, a, d, s, q);
            mem[a] = merge(mem.exists(a) ? mem[a] : d, d, s);
            op(1, a, ~d, 4'hf, q);
            op(0, a, d, 4'h0, q);
            chk("word", mem[a], q);
         end
         $display("test mode %0d done", m);
      end
      axi(1, OFS_CFG, 32'(1 << CFG_SLEEP), r);
      repeat (6) @(posedge sys_clk);
      op(1, a, ~mem[a], 4'h0, q);
      axi(1, OFS_CFG, 32'h0, r);
      repeat (6) @(posedge sys_clk);
      op(0, a, 36'h0, 4'h0, q);
      chk("sleep", mem[a], q);
      $display("test sleep done");
      report_and_stop;
   end

   // about 120 operations of under 80 cycles each
   initial begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      report_and_stop;
   end
endmodule
